/* verilog/ctw_core.sv */
`timescale 1ns/1ps
module ctw_core
	import ctw_pkg::*;
#(
	parameter int TXTO_CYC = CTW_TXTO_CYC,
	parameter int BUSTO_CYC = CTW_BUSTO_CYC
) (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic [7:0] s_awaddr_i,
	input wire logic s_awvalid_i,
	output logic s_awready_o,
	input wire logic [31:0] s_wdata_i,
	input wire logic [3:0] s_wstrb_i,
	input wire logic s_wvalid_i,
	output logic s_wready_o,
	output logic [1:0] s_bresp_o,
	output logic s_bvalid_o,
	input wire logic s_bready_i,
	input wire logic [7:0] s_araddr_i,
	input wire logic s_arvalid_i,
	output logic s_arready_o,
	output logic [31:0] s_rdata_o,
	output logic [1:0] s_rresp_o,
	output logic s_rvalid_o,
	input wire logic s_rready_i,
	input wire ctw_line_t line_i,
	input wire logic restart_done_i,
	output logic driver_en_o,
	output logic receive_out_o,
	output logic int_b_o,
	output logic watchdog_en_o,
	output logic [2:0] sys_mode_o
);
	ctw_xmode_t xmode;
	ctw_smode_t smode;
	ctw_wk_t wk_state;
	logic watchdog_on_bus_wake;
	logic fail_flag, uv_flag, bus_wake_flag, tx_off, uv_off, armed, woken, int_pend;
	logic [CTW_CNT_W-1:0] tx_cnt, bus_cnt, wk_cnt;
	logic bus_prev, tx_prev;
	logic aw_hold, w_hold;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;

	function automatic logic [CTW_CNT_W-1:0] ctw_inc(input logic [CTW_CNT_W-1:0] c);
		ctw_inc = (c == {CTW_CNT_W{1'b1}}) ? c : c + 1'b1;
	endfunction

	// Dominant is a low level on both the bus receiver and the transmit input
	wire bus_dom = ~line_i.bus_level;
	wire tx_dom = ~line_i.bus_transmit_in;
	wire sys_ns = (smode == CTW_SYS_NORMAL) || (smode == CTW_SYS_STOP);
	wire act_mode = (xmode == CTW_NORMAL) || (xmode == CTW_RXONLY);
	wire uv_mon = act_mode && sys_ns;

	// Register write path: address and data may arrive in either order
	wire wr_go = aw_hold && w_hold && !s_bvalid_o;
	wire wr_ctrl = wr_go && (aw_addr == CTW_ADDR_CTRL) && w_strb[0];
	wire wr_ctrl_hi = wr_go && (aw_addr == CTW_ADDR_CTRL) && w_strb[1];
	wire wr_stat = wr_go && (aw_addr == CTW_ADDR_STAT) && w_strb[0];
	wire wr_ok = (aw_addr == CTW_ADDR_CTRL) || (aw_addr == CTW_ADDR_STAT);
	wire [1:0] req_mode = w_data[CTW_CTRL_MODE_LSB +: 2];
	wire [2:0] req_sys = w_data[CTW_CTRL_SYS_LSB +: 3];
	// Receive-only only in system normal/stop; wake-capable not from init
	wire mode_legal = (req_mode == CTW_RXONLY || req_mode == CTW_NORMAL) ? sys_ns :
		(req_mode == CTW_WAKE) ? (smode != CTW_SYS_INIT) : 1'b1;
	wire set_mode = wr_ctrl && mode_legal && (smode != CTW_SYS_FAILSAFE);
	wire set_sys = wr_ctrl && (req_sys != smode) && (req_sys <= CTW_SYS_FAILSAFE);
	wire to_stop_fs = set_sys && (req_sys == CTW_SYS_STOP || req_sys == CTW_SYS_FAILSAFE);
	// A write that takes the mode out of wake-capable rearms detection
	wire leave_wake = set_mode && (xmode == CTW_WAKE) && (req_mode != CTW_WAKE);

	// Wake pattern filter
	wire wk_long = wk_cnt >= CTW_CNT_W'(CTW_WAKE2_CYC);
	wire wk_ok = (wk_cnt >= CTW_CNT_W'(CTW_WAKE1_CYC)) && !wk_long;
	wire wk_edge = bus_dom != bus_prev;
	wire wake_hit = (wk_state == CTW_WK_DOM2) && wk_edge && wk_ok && armed
		&& (xmode == CTW_WAKE);
	wire tx_to = tx_dom && (tx_cnt >= CTW_CNT_W'(TXTO_CYC));
	wire bus_to = bus_dom && (bus_cnt >= CTW_CNT_W'(BUSTO_CYC));
	wire int_wake = wake_hit && sys_ns;

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			wk_state <= CTW_WK_IDLE;
			wk_cnt <= '0;
			bus_prev <= 1'b0;
		end else begin
			bus_prev <= bus_dom;
			wk_cnt <= wk_edge ? '0 : ctw_inc(wk_cnt);
			if (xmode != CTW_WAKE || !armed) begin
				wk_state <= CTW_WK_IDLE;
			end else begin
				case (wk_state)
					CTW_WK_IDLE: if (wk_edge && bus_dom) wk_state <= CTW_WK_DOM1;
					CTW_WK_DOM1: if (wk_edge) wk_state <= wk_ok ? CTW_WK_REC : CTW_WK_IDLE;
					CTW_WK_REC: if (wk_edge) wk_state <= wk_ok ? CTW_WK_DOM2 : CTW_WK_DOM1;
					CTW_WK_DOM2: if (wk_edge) wk_state <= wk_ok ? CTW_WK_DONE : CTW_WK_IDLE;
					CTW_WK_DONE: wk_state <= CTW_WK_DONE;
					default: wk_state <= CTW_WK_IDLE;
				endcase
				// A phase already too long cannot complete the pattern
				if (wk_long && wk_state != CTW_WK_IDLE && wk_state != CTW_WK_DONE)
					wk_state <= CTW_WK_IDLE;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			tx_cnt <= '0;
			bus_cnt <= '0;
			tx_prev <= 1'b0;
		end else begin
			tx_prev <= tx_dom;
			tx_cnt <= (tx_dom != tx_prev || !tx_dom) ? '0 : ctw_inc(tx_cnt);
			bus_cnt <= (wk_edge || !bus_dom) ? '0 : ctw_inc(bus_cnt);
		end
	end

	// Mode, system mode and wake state
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			xmode <= CTW_OFF;
			smode <= CTW_SYS_INIT;
			armed <= 1'b1;
			woken <= 1'b0;
			watchdog_on_bus_wake <= 1'b0;
			watchdog_en_o <= 1'b0;
		end else begin
			if (wr_ctrl_hi) begin
				watchdog_on_bus_wake <= w_data[CTW_CTRL_WDWK_BIT];
				watchdog_en_o <= w_data[CTW_CTRL_WDEN_BIT];
			end
			if (set_mode) begin
				xmode <= ctw_xmode_t'(req_mode);
			end
			if (set_sys) begin
				smode <= ctw_smode_t'(req_sys);
				if (req_sys == CTW_SYS_FAILSAFE) xmode <= CTW_WAKE;
			end
			if (leave_wake) begin
				armed <= 1'b1;
				woken <= 1'b0;
			end else if (set_mode && req_mode != CTW_WAKE) begin
				woken <= 1'b0;
			end
			if (to_stop_fs) armed <= 1'b1;
			if (wake_hit) begin
				armed <= 1'b0;
				woken <= 1'b1;
				// Stop and normal stay put; others go to restart
				if (!sys_ns) smode <= CTW_SYS_RESTART;
				if (smode == CTW_SYS_STOP && watchdog_on_bus_wake)
					watchdog_en_o <= 1'b1;
			end else if (smode == CTW_SYS_RESTART && restart_done_i && !set_sys) begin
				smode <= CTW_SYS_NORMAL;
			end
		end
	end

	// Driver fallbacks and sticky flags; hardware set wins over software clear
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			fail_flag <= 1'b0;
			uv_flag <= 1'b0;
			bus_wake_flag <= 1'b0;
			int_pend <= 1'b0;
			tx_off <= 1'b0;
			uv_off <= 1'b0;
		end else begin
			tx_off <= (xmode == CTW_NORMAL) && (tx_off ? tx_dom : tx_to);
			uv_off <= uv_mon && line_i.supply_low;
			if (wr_stat && w_data[CTW_STAT_FAIL_BIT]) fail_flag <= 1'b0;
			if (wr_stat && w_data[CTW_STAT_UV_BIT]) uv_flag <= 1'b0;
			if (wr_stat && w_data[CTW_STAT_WAKE_BIT]) begin
				bus_wake_flag <= 1'b0;
				int_pend <= 1'b0;
			end
			if ((xmode == CTW_NORMAL && tx_to) || (act_mode && bus_to))
				fail_flag <= 1'b1;
			if (uv_mon && line_i.supply_low) uv_flag <= 1'b1;
			if (wake_hit) bus_wake_flag <= 1'b1;
			if (int_wake) int_pend <= 1'b1;
		end
	end

	// Pin outputs; transmission only after a recessive level once enabled
	logic tx_armed;
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			tx_armed <= 1'b0;
			driver_en_o <= 1'b0;
			receive_out_o <= 1'b1;
			int_b_o <= 1'b1;
			sys_mode_o <= CTW_SYS_INIT;
		end else begin
			if (xmode != CTW_NORMAL) tx_armed <= 1'b0;
			else if (!tx_dom) tx_armed <= 1'b1;
			driver_en_o <= (xmode == CTW_NORMAL) && tx_armed && !tx_off && !uv_off
				&& tx_dom;
			if (xmode == CTW_WAKE) receive_out_o <= !(woken || wake_hit);
			else if (act_mode) receive_out_o <= line_i.bus_level;
			else receive_out_o <= 1'b1;
			int_b_o <= !(int_pend || int_wake);
			sys_mode_o <= smode;
		end
	end

	// AXI4-Lite slave, one write and one read at a time
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			aw_hold <= 1'b0;
			w_hold <= 1'b0;
			aw_addr <= '0;
			w_data <= '0;
			w_strb <= '0;
			s_bvalid_o <= 1'b0;
			s_bresp_o <= CTW_RESP_OKAY;
			s_arready_o <= 1'b0;
			s_rvalid_o <= 1'b0;
			s_rdata_o <= '0;
			s_rresp_o <= CTW_RESP_OKAY;
		end else begin
			if (s_awvalid_i && s_awready_o) begin
				aw_hold <= 1'b1;
				aw_addr <= s_awaddr_i;
			end
			if (s_wvalid_i && s_wready_o) begin
				w_hold <= 1'b1;
				w_data <= s_wdata_i;
				w_strb <= s_wstrb_i;
			end
			if (wr_go) begin
				aw_hold <= 1'b0;
				w_hold <= 1'b0;
				s_bvalid_o <= 1'b1;
				s_bresp_o <= wr_ok ? CTW_RESP_OKAY : CTW_RESP_SLVERR;
			end else if (s_bvalid_o && s_bready_i) begin
				s_bvalid_o <= 1'b0;
			end
			s_arready_o <= !s_arready_o && s_arvalid_i && !s_rvalid_o;
			if (s_arready_o && s_arvalid_i) begin
				s_rvalid_o <= 1'b1;
				s_rresp_o <= CTW_RESP_OKAY;
				case (s_araddr_i)
					CTW_ADDR_CTRL: s_rdata_o <= {22'h000000, watchdog_en_o,
						watchdog_on_bus_wake, 1'b0, smode, 2'b00, xmode};
					CTW_ADDR_STAT: s_rdata_o <= {22'h000000, !uv_off && !tx_off && xmode == CTW_NORMAL,
						driver_en_o, 3'b000, armed, tx_off, bus_wake_flag, uv_flag, fail_flag};
					CTW_ADDR_WAKE: s_rdata_o <= {31'h00000000, bus_wake_flag};
					default: begin
						s_rdata_o <= 32'h00000000;
						s_rresp_o <= CTW_RESP_SLVERR;
					end
				endcase
			end else if (s_rvalid_o && s_rready_i) begin
				s_rvalid_o <= 1'b0;
			end
		end
	end

	assign s_awready_o = !aw_hold && !s_bvalid_o;
	assign s_wready_o = !w_hold && !s_bvalid_o;

	chk_wake_rx_low: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		wake_hit |=> !receive_out_o) else $error("receive output not low after wake");
	chk_wake_mode_kept: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		wake_hit |=> xmode == CTW_WAKE) else $error("mode left wake-capable on wake");
	chk_off_no_wake: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		xmode == CTW_OFF |-> !wake_hit) else $error("wake accepted in off mode");
	chk_sleep_no_int: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(wake_hit && smode == CTW_SYS_SLEEP && !int_pend) |=> int_b_o)
		else $error("interrupt on sleep wake");
	chk_stop_int: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(wake_hit && smode == CTW_SYS_STOP) |=> !int_b_o && smode == CTW_SYS_STOP)
		else $error("stop wake handling wrong");
	chk_sleep_restart: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(wake_hit && smode == CTW_SYS_SLEEP) |=> smode == CTW_SYS_RESTART)
		else $error("sleep wake did not restart");
	chk_tx_timeout: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(xmode == CTW_NORMAL && tx_to && !set_mode) |=> ##1 !driver_en_o)
		else $error("driver on after transmit time-out");
	chk_fail_sticky: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(fail_flag && !(wr_stat && w_data[CTW_STAT_FAIL_BIT])) |=> fail_flag)
		else $error("failure flag lost");
	chk_stop_rearm: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(to_stop_fs && !wake_hit) |=> armed) else $error("no rearm on stop");

	// Driver and receive pin guards per transceiver mode, and fault flag checks
	chk_rxonly_no_drive: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		xmode == CTW_RXONLY |=> !driver_en_o)
		else $error("driver on in receive-only mode");
	chk_off_rx_high: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		xmode == CTW_OFF |=> receive_out_o)
		else $error("receive output low in off mode");
	chk_uv_driver_off: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		uv_off |=> !driver_en_o)
		else $error("driver on during supply low");
	chk_uv_flag_set: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(uv_mon && line_i.supply_low) |=> uv_flag)
		else $error("supply low flag not set");
	chk_bus_to_fail: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(act_mode && bus_to) |=> fail_flag)
		else $error("bus time-out did not set failure flag");
	chk_tx_off_clear: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(tx_off && !tx_dom) |=> !tx_off)
		else $error("driver fallback kept after time-out ended");

	// System mode reactions tied to fail-safe
	chk_fs_forces_wake: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(set_sys && req_sys == CTW_SYS_FAILSAFE) |=> xmode == CTW_WAKE)
		else $error("fail-safe did not force wake-capable mode");
	chk_fs_wake_restart: assert property (@(posedge clk_i) disable iff (!rst_b_i)
		(wake_hit && smode == CTW_SYS_FAILSAFE && !int_pend) |=> smode == CTW_SYS_RESTART && int_b_o)
		else $error("fail-safe wake handling wrong");
endmodule // ctw_core

/* include/ctw_pkg.sv */
package ctw_pkg;
	// Transceiver mode codes held in the mode field
	typedef enum logic [1:0] {
		CTW_OFF = 2'b00,
		CTW_WAKE = 2'b01,
		CTW_RXONLY = 2'b10,
		CTW_NORMAL = 2'b11
	} ctw_xmode_t;
	// System mode codes
	typedef enum logic [2:0] {
		CTW_SYS_INIT = 3'b000,
		CTW_SYS_NORMAL = 3'b001,
		CTW_SYS_STOP = 3'b010,
		CTW_SYS_SLEEP = 3'b011,
		CTW_SYS_RESTART = 3'b100,
		CTW_SYS_FAILSAFE = 3'b101
	} ctw_smode_t;
	// Wake detector states
	typedef enum logic [2:0] {
		CTW_WK_IDLE = 3'b000,
		CTW_WK_DOM1 = 3'b001,
		CTW_WK_REC = 3'b010,
		CTW_WK_DOM2 = 3'b011,
		CTW_WK_DONE = 3'b100
	} ctw_wk_t;
	// Register byte addresses
	localparam logic [7:0] CTW_ADDR_CTRL = 8'h00;
	localparam logic [7:0] CTW_ADDR_STAT = 8'h04;
	localparam logic [7:0] CTW_ADDR_WAKE = 8'h08;
	// Control register fields
	localparam int CTW_CTRL_MODE_LSB = 0;
	localparam int CTW_CTRL_SYS_LSB = 4;
	localparam int CTW_CTRL_WDWK_BIT = 8;
	localparam int CTW_CTRL_WDEN_BIT = 9;
	// Status register fields (bits 0 to 2 write one to clear)
	localparam int CTW_STAT_FAIL_BIT = 0;
	localparam int CTW_STAT_UV_BIT = 1;
	localparam int CTW_STAT_WAKE_BIT = 2;
	localparam int CTW_STAT_TXOFF_BIT = 3;
	localparam int CTW_STAT_ARMED_BIT = 4;
	localparam int CTW_STAT_EFF_LSB = 8;
	localparam logic [1:0] CTW_RESP_OKAY = 2'b00;
	localparam logic [1:0] CTW_RESP_SLVERR = 2'b10;
	// Times in ns at a 10 ns clock
	localparam int CTW_CLK_NS = 10;
	localparam int CTW_WAKE1_NS = 500;
	localparam int CTW_WAKE2_NS = 1800;
	localparam int CTW_TXTO_NS = 2700000;
	localparam int CTW_BUSTO_NS = 2700000;
	localparam int CTW_WAKE1_CYC = (CTW_WAKE1_NS + CTW_CLK_NS - 1) / CTW_CLK_NS;
	localparam int CTW_WAKE2_CYC = CTW_WAKE2_NS / CTW_CLK_NS;
	localparam int CTW_TXTO_CYC = (CTW_TXTO_NS + CTW_CLK_NS - 1) / CTW_CLK_NS;
	localparam int CTW_BUSTO_CYC = (CTW_BUSTO_NS + CTW_CLK_NS - 1) / CTW_CLK_NS;
	localparam int CTW_CNT_W = 20;
	// Bus-side levels grouped
	typedef struct packed {
		logic bus_transmit_in;
		logic bus_level;
		logic supply_low;
	} ctw_line_t;
endpackage

/* verification/ctw_host_model.sv */
`timescale 1ns/1ps
module ctw_host_model (
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic send_i,
	input wire logic [15:0] len_i,
	output logic tx_o,
	output logic busy_o
);
	logic [15:0] cnt;
	// One dominant burst per request; a burst in flight ignores new requests
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cnt <= 16'h0000;
		end else if (send_i && cnt == 16'h0000) begin
			cnt <= len_i;
		end else if (cnt != 16'h0000) begin
			cnt <= cnt - 16'h0001;
		end
	end
	// Recessive whenever no burst runs, so enabling never meets a held dominant
	assign tx_o = (cnt == 16'h0000);
	assign busy_o = (cnt != 16'h0000);
endmodule // ctw_host_model

/* verification/tb_top.sv */
`timescale 1ns/1ps
module tb_top
	import ctw_pkg::*;
;
	localparam logic [7:0] AC = CTW_ADDR_CTRL;
	localparam logic [7:0] AS = CTW_ADDR_STAT;
	logic clk_i, rst_b_i, av, wv, bb, arv, rr, bus_r, uv, rdn, snd, tx, busy, pg;
	logic awr, wrd, bv, arr, rv, drv, rxo, intb, wde;
	logic [7:0] aa, ra;
	logic [31:0] wd, rdat, seed;
	logic [3:0] ws;
	logic [15:0] dl;
	logic [1:0] bresp, rresp;
	logic [2:0] sm;
	logic [65:0] rq;
	logic [65:0] rd_q[$];
	logic [6:0] pin_q[$];
	int failures, checks;
	ctw_line_t ln;
	// Bus shows dominant while our own driver is on
	assign ln = {tx, bus_r & ~drv, uv};
	wire [6:0] pins = {sm, wde, intb, rxo, drv};
	ctw_core #(.TXTO_CYC(200), .BUSTO_CYC(200)) u_dut (
		.clk_i(clk_i), .rst_b_i(rst_b_i), .s_awaddr_i(aa), .s_awvalid_i(av),
		.s_awready_o(awr), .s_wdata_i(wd), .s_wstrb_i(ws), .s_wvalid_i(wv),
		.s_wready_o(wrd), .s_bresp_o(bresp), .s_bvalid_o(bv), .s_bready_i(bb),
		.s_araddr_i(ra), .s_arvalid_i(arv), .s_arready_o(arr), .s_rdata_o(rdat),
		.s_rresp_o(rresp), .s_rvalid_o(rv), .s_rready_i(rr), .line_i(ln),
		.restart_done_i(rdn), .driver_en_o(drv), .receive_out_o(rxo), .int_b_o(intb),
		.watchdog_en_o(wde), .sys_mode_o(sm));
	ctw_host_model u_host (.clk_i(clk_i), .rst_b_i(rst_b_i), .send_i(snd), .len_i(dl),
		.tx_o(tx), .busy_o(busy));
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic int rl();
		return 60 + int'(xs() % 32'd110);
	endfunction
	function automatic logic [31:0] cw(input logic [2:0] s, input logic [1:0] m, input logic k);
		return {22'h0, 1'b0, k, 1'b0, s, 2'h0, m};
	endfunction
	task automatic cmp(input logic [33:0] g, input logic [33:0] e);
		checks++;
		if (g !== e) begin
			failures++;
			$display("ERROR at %0t: got %0h expected %0h", $time, g, e);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic ta, tw;
		ta = 1'b0;
		tw = 1'b0;
		{aa, wd, ws} <= {a, d, 4'hF};
		{av, wv, bb} <= 3'h7;
		do begin
			@(posedge clk_i);
			ta = ta | (awr & av);
			tw = tw | (wrd & wv);
			av <= av & ~awr;
			wv <= wv & ~wrd;
		end while (!(ta && tw));
		while (!bv) @(posedge clk_i);
		bb <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic rd(input logic [7:0] a, input logic [33:0] e, input logic [31:0] m);
		rd_q.push_back({e, m});
		ra <= a;
		{arv, rr} <= 2'h3;
		do @(posedge clk_i); while (!arr);
		arv <= 1'b0;
		while (!rv) @(posedge clk_i);
		rr <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic pc(input logic [6:0] e);
		pin_q.push_back(e);
		pg <= 1'b1;
		@(posedge clk_i);
		pg <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic wk(input int d1, input int r, input int d2);
		bus_r <= 1'b0;
		repeat (d1) @(posedge clk_i);
		bus_r <= 1'b1;
		repeat (r) @(posedge clk_i);
		bus_r <= 1'b0;
		repeat (d2) @(posedge clk_i);
		bus_r <= 1'b1;
		repeat (4) @(posedge clk_i);
	endtask
	task automatic xmit(input logic [15:0] n);
		{snd, dl} <= {1'b1, n};
		@(posedge clk_i);
		snd <= 1'b0;
		repeat (3) @(posedge clk_i);
	endtask
	task automatic idle();
		while (busy) @(posedge clk_i);
		repeat (3) @(posedge clk_i);
	endtask
	always @(posedge clk_i) begin
		if (rv && rr) begin
			rq = rd_q.pop_front();
			cmp({rresp, rdat & rq[31:0]}, rq[65:32]);
		end
		if (pg) cmp({27'h0, pins}, {27'h0, pin_q.pop_front()});
	end
	initial begin
		#200000;
		failures++;
		stop_test();
	end
	initial begin
		{rst_b_i, av, wv, bb, arv, rr, snd, uv, rdn, pg} = '0;
		{aa, ra, wd, ws, dl} = '0;
		{bus_r, seed, failures, checks} = {1'b1, 32'd49, 32'd0, 32'd0};
		repeat (3) @(posedge clk_i);
		rst_b_i <= 1'b1;
		@(posedge clk_i);
		pc({3'h0, 4'h6});
		wr(8'h0C, xs());
		rd(AC, 34'h0, 32'h3FF);
		rd(8'h0C, {2'h2, 32'h0}, 32'hFFFFFFFF);
		wr(AC, cw(3'h1, 2'h0, 1'b0));
		wk(rl(), rl(), rl());
		pc({3'h1, 4'h6});
		$display("test reset and off mode finished");
		wr(AC, cw(3'h1, 2'h1, 1'b0));
		wk(rl(), rl(), rl());
		pc({3'h1, 4'h0});
		rd(AC, 34'h11, 32'h73);
		rd(AS, 34'h4, 32'h4);
		rd(CTW_ADDR_WAKE, 34'h1, 32'h1);
		wr(AC, cw(3'h1, 2'h0, 1'b0));
		pc({3'h1, 4'h2});
		wr(AC, cw(3'h1, 2'h1, 1'b0));
		wk(20, 20, 20);
		pc({3'h1, 4'h2});
		wk(200, 100, 100);
		pc({3'h1, 4'h2});
		wk(rl(), rl(), rl());
		pc({3'h1, 4'h0});
		wr(AS, 32'h7);
		pc({3'h1, 4'h4});
		$display("test wake in normal finished");
		wr(AC, cw(3'h2, 2'h1, 1'b1));
		wk(rl(), rl(), rl());
		pc({3'h2, 4'h8});
		wr(AS, 32'h4);
		wr(AC, cw(3'h2, 2'h0, 1'b0));
		wr(AC, cw(3'h2, 2'h1, 1'b0));
		wr(AC, cw(3'h3, 2'h1, 1'b0));
		wk(rl(), rl(), rl());
		pc({3'h4, 4'h4});
		rdn <= 1'b1;
		repeat (3) @(posedge clk_i);
		rdn <= 1'b0;
		pc({3'h1, 4'h4});
		$display("test wake in stop and sleep finished");
		wr(AC, cw(3'h5, 2'h0, 1'b0));
		rd(AC, 34'h51, 32'h73);
		wk(rl(), rl(), rl());
		pc({3'h4, 4'h4});
		rdn <= 1'b1;
		repeat (3) @(posedge clk_i);
		rdn <= 1'b0;
		$display("test fail-safe finished");
		wr(AS, 32'h7);
		wr(AC, cw(3'h1, 2'h3, 1'b0));
		pc({3'h1, 4'h6});
		xmit(16'h0028);
		pc({3'h1, 4'h5});
		idle();
		xmit(16'h012C);
		repeat (230) @(posedge clk_i);
		pc({3'h1, 4'h6});
		rd(AS, 34'h1, 32'h1);
		rd(AC, 34'h13, 32'h73);
		idle();
		xmit(16'h0014);
		pc({3'h1, 4'h5});
		idle();
		rd(AS, 34'h1, 32'h1);
		wr(AS, 32'h1);
		rd(AS, 34'h0, 32'h1);
		$display("test transmit time-out finished");
		uv <= 1'b1;
		xmit(16'h0028);
		pc({3'h1, 4'h6});
		idle();
		rd(AS, 34'h2, 32'h2);
		uv <= 1'b0;
		xmit(16'h0028);
		pc({3'h1, 4'h5});
		idle();
		rd(AS, 34'h2, 32'h2);
		$display("test supply low finished");
		wr(AC, cw(3'h1, 2'h2, 1'b0));
		xmit(16'h0028);
		pc({3'h1, 4'h6});
		idle();
		wr(AS, 32'h7);
		wk(150, 2, 150);
		rd(AS, 34'h0, 32'h1);
		bus_r <= 1'b0;
		repeat (3) @(posedge clk_i);
		pc({3'h1, 4'h4});
		repeat (230) @(posedge clk_i);
		rd(AS, 34'h1, 32'h1);
		rd(AC, 34'h12, 32'h73);
		bus_r <= 1'b1;
		$display("test receive-only finished");
		stop_test();
	end
endmodule // tb_top
